// ===== rpsm_port_status.sv
// Purpose: Per-receive-port status and rate registers
// Assumes: Register strobes come from the control-interface target
// Notes:   Events are ref_clk pulses; rate_clk_in is asynchronous
//
// Behaviour
// RULE1 - Each register exists per port and the port-select register picks the copy accessed.
// RULE2 - The unsteady-row-width flag sets when a frame's lines differ and holds until read.
// RULE3 - The row-width-changed flag sets on a detected change and clears on read.
// RULE4 - The line-code-fault flag sets on an encoding error and clears on read.
// RULE5 - Encoding errors count only with fault counting on and a limit above one.
// RULE6 - The packet-buffer flag sets on a buffer overflow and clears on read.
// RULE7 - Bit 3 shows a camera receive error live and a read does not clear it.
// RULE8 - Bit 1 shows a missing input clock when the rate is below the low limit.
// RULE9 - The row-count-changed flag sets on a detected change and clears on read.
// RULE10 - The integer MHz rate is readable and bit 2 shows when it has settled.
// RULE11 - The fraction byte gives the rate in steps of 1/256 MHz.
// RULE12 - Sensor status byte zero loads from the forward channel; writes do nothing.
// RULE13 - A flag clears only on a read of its port and an event in that cycle wins.

`timescale 1ns/1ns

module rpsm_port_status
    import rpsm_pkg::*;
#(
    parameter int NP         = 4,
    parameter int WINDOW_CYC = MEAS_WINDOW_CYC
)(
    // Clock, reset, enable
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic                ce,
    // Register access
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr_en,
    input  wire logic                reg_rd_en,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    // Receiver events, one-cycle pulses
    input  wire logic [NP-1:0]       row_width_unsteady_evt,
    input  wire logic [NP-1:0]       row_width_changed_evt,
    input  wire logic [NP-1:0]       row_count_changed_evt,
    input  wire logic [NP-1:0]       line_code_fault_evt,
    input  wire logic [NP-1:0]       packet_buf_overflow_evt,
    // Camera receive error level
    input  wire logic [NP-1:0]       camera_rx_error,
    // Fault counting and rate detect setup
    input  wire logic                link_fault_count_en,
    input  wire logic [7:0]          link_fault_limit,
    input  wire logic [7:0]          rate_low_limit,
    // Link rate samples, asynchronous
    input  wire logic [NP-1:0]       rate_clk_in,
    // Forward-channel sensor status
    input  wire logic [NP-1:0]       fwd_status_valid,
    input  wire logic [NP-1:0][7:0]  fwd_status_byte
);

    localparam int PSEL_W = $clog2(NP);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PSEL_W-1:0]    port_sel;
        logic [NP-1:0]        unsteady;
        logic [NP-1:0]        len_chg;
        logic [NP-1:0]        code_fault;
        logic [NP-1:0]        buf_err;
        logic [NP-1:0]        cnt_chg;
        logic [NP-1:0][7:0]   sensor;
        logic [7:0]           rdata;
    } rpsm_state_t;

    rpsm_state_t          st_reg;
    rpsm_state_t          st_next;
    logic [NP-1:0]        clr;
    logic [NP-1:0]        code_evt;
    logic                 code_ok;
    logic                 rd_sts;
    logic [7:0]           sts_byte;
    logic [NP-1:0][7:0]   m_int;
    logic [NP-1:0][7:0]   m_frac;
    logic [NP-1:0]        m_settled;
    logic [NP-1:0]        m_missing;

    // ------------------------------------------------------------
    // Rate meters, one per port
    // ------------------------------------------------------------
    for (genvar g = 0; g < NP; g++)
    begin : gm
        rpsm_rate_meter #(
            .WINDOW_CYC (WINDOW_CYC)
        ) u_meter (
            .ref_clk              (ref_clk),
            .srst                 (srst),
            .ce                   (ce),
            .rate_clk_in          (rate_clk_in[g]),
            .rate_low_limit       (rate_low_limit),
            .rate_integer_mhz     (m_int[g]),
            .rate_fraction_mhz    (m_frac[g]),
            .rate_measure_settled (m_settled[g]),
            .input_clock_missing  (m_missing[g])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        rd_sts  = reg_rd_en && (reg_addr == ADDR_STS_TWO);
        // Clear-on-read only hits the selected port's copy
        clr     = '0;
        if (rd_sts)
        begin
            clr[st_reg.port_sel] = 1'b1; // see RULE13
        end
        // A limit of one loses lock before the error can be seen
        code_ok  = link_fault_count_en &&
            (link_fault_limit > CODE_LIMIT_MIN); // see RULE5
        code_evt = line_code_fault_evt & {NP{code_ok}};

        // Set wins over clear in the same cycle
        st_next.unsteady   = (st_reg.unsteady & ~clr)
            | row_width_unsteady_evt; // see RULE2
        st_next.len_chg    = (st_reg.len_chg & ~clr)
            | row_width_changed_evt; // see RULE3
        st_next.code_fault = (st_reg.code_fault & ~clr)
            | code_evt; // see RULE4
        st_next.buf_err    = (st_reg.buf_err & ~clr)
            | packet_buf_overflow_evt; // see RULE6
        st_next.cnt_chg    = (st_reg.cnt_chg & ~clr)
            | row_count_changed_evt; // see RULE9

        for (int p = 0; p < NP; p++)
        begin
            if (fwd_status_valid[p])
            begin
                st_next.sensor[p] = fwd_status_byte[p]; // see RULE12
            end
        end

        sts_byte               = RST_BYTE;
        sts_byte[BIT_UNSTEADY] = st_reg.unsteady[st_reg.port_sel];
        sts_byte[BIT_LEN_CHG]  = st_reg.len_chg[st_reg.port_sel];
        sts_byte[BIT_CODE]     = st_reg.code_fault[st_reg.port_sel];
        sts_byte[BIT_BUF]      = st_reg.buf_err[st_reg.port_sel];
        sts_byte[BIT_CAM]      = camera_rx_error[st_reg.port_sel]; // see RULE7
        sts_byte[BIT_SETTLED]  = m_settled[st_reg.port_sel]; // see RULE10
        sts_byte[BIT_MISSING]  = m_missing[st_reg.port_sel]; // see RULE8
        sts_byte[BIT_CNT_CHG]  = st_reg.cnt_chg[st_reg.port_sel];

        // Port select; an index beyond the last port is ignored
        if (reg_wr_en && (reg_addr == ADDR_PORT_SEL))
        begin
            if (int'(reg_wdata) < NP)
            begin
                st_next.port_sel = reg_wdata[PSEL_W-1:0]; // see RULE1
            end
        end

        // Read data holds until the next read; status bytes are read-only
        if (reg_rd_en)
        begin
            if (reg_addr == ADDR_PORT_SEL)
            begin
                st_next.rdata = RST_BYTE;
                st_next.rdata[PSEL_W-1:0] = st_reg.port_sel;
            end
            else if (reg_addr == ADDR_STS_TWO)
            begin
                st_next.rdata = sts_byte; // see RULE1
            end
            else if (reg_addr == ADDR_FREQ_INT)
            begin
                st_next.rdata = m_int[st_reg.port_sel]; // see RULE10
            end
            else if (reg_addr == ADDR_FREQ_FRAC)
            begin
                st_next.rdata = m_frac[st_reg.port_sel]; // see RULE11
            end
            else if (reg_addr == ADDR_SENSOR0)
            begin
                st_next.rdata = st_reg.sensor[st_reg.port_sel];
            end
            else
            begin
                st_next.rdata = RST_BYTE;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_reg          <= '0;
            st_reg.port_sel <= RST_PORT_SEL[PSEL_W-1:0];
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;

    // ------------------------------------------------------------
    // Checks on the read path
    // ------------------------------------------------------------
    property p_sel_read;
        @(posedge ref_clk) disable iff (srst)
        (ce && rd_sts) |=> (reg_rdata[BIT_LEN_CHG] ==
            $past(st_reg.len_chg[st_reg.port_sel]));
    endproperty
    a_sel_read: assert property (p_sel_read) // see RULE1
        else $error("status read shows wrong port copy");

    property p_cam_keep;
        @(posedge ref_clk) disable iff (srst)
        (ce && rd_sts) |=> (reg_rdata[BIT_CAM] ==
            $past(camera_rx_error[st_reg.port_sel]));
    endproperty
    a_cam_keep: assert property (p_cam_keep) // see RULE7
        else $error("camera error bit does not follow its source");

    property p_freq_read;
        @(posedge ref_clk) disable iff (srst)
        (ce && reg_rd_en && (reg_addr == ADDR_FREQ_INT))
            |=> (reg_rdata == $past(m_int[st_reg.port_sel]));
    endproperty
    a_freq_read: assert property (p_freq_read) // see RULE10
        else $error("rate integer read is wrong");

    // ------------------------------------------------------------
    // Per-port flag checks
    // ------------------------------------------------------------
    for (genvar q = 0; q < NP; q++)
    begin : gc
        property p_unsteady_set;
            @(posedge ref_clk) disable iff (srst)
            (ce && row_width_unsteady_evt[q]) |=> st_reg.unsteady[q];
        endproperty
        a_unsteady_set: assert property (p_unsteady_set) // see RULE2
            else $error("unsteady flag missed its event");

        property p_len_clear;
            @(posedge ref_clk) disable iff (srst)
            (ce && clr[q] && !row_width_changed_evt[q])
                |=> !st_reg.len_chg[q];
        endproperty
        a_len_clear: assert property (p_len_clear) // see RULE3
            else $error("row width flag not cleared by read");

        property p_code_set;
            @(posedge ref_clk) disable iff (srst)
            (ce && line_code_fault_evt[q] && link_fault_count_en &&
                (link_fault_limit > CODE_LIMIT_MIN))
                |=> st_reg.code_fault[q];
        endproperty
        a_code_set: assert property (p_code_set) // see RULE4
            else $error("line code fault not flagged");

        property p_code_mask;
            @(posedge ref_clk) disable iff (srst)
            (ce && !clr[q] && (!link_fault_count_en ||
                (link_fault_limit <= CODE_LIMIT_MIN)))
                |=> $stable(st_reg.code_fault[q]);
        endproperty
        a_code_mask: assert property (p_code_mask) // see RULE5
            else $error("line code fault flagged while masked");

        property p_buf_hold;
            @(posedge ref_clk) disable iff (srst)
            (st_reg.buf_err[q] && !clr[q]) |=> st_reg.buf_err[q];
        endproperty
        a_buf_hold: assert property (p_buf_hold) // see RULE6
            else $error("buffer flag lost without a read");

        property p_cnt_race;
            @(posedge ref_clk) disable iff (srst)
            (ce && clr[q] && row_count_changed_evt[q])
                |=> st_reg.cnt_chg[q];
        endproperty
        a_cnt_race: assert property (p_cnt_race) // see RULE13
            else $error("event lost against clearing read");

        property p_sensor_load;
            @(posedge ref_clk) disable iff (srst)
            (ce && fwd_status_valid[q])
                |=> (st_reg.sensor[q] == $past(fwd_status_byte[q]));
        endproperty
        a_sensor_load: assert property (p_sensor_load) // see RULE12
            else $error("sensor status not loaded");
    end

endmodule

// ===== rpsm_pkg.sv
// Purpose: Shared constants of the receive-port status monitor
// Assumes: 100 MHz reference clock, 8-bit register space
// Notes:   Used by rpsm_rate_meter and rpsm_port_status

package rpsm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_SEL  = 8'h4C;
    localparam logic [7:0] ADDR_STS_TWO   = 8'h4E;
    localparam logic [7:0] ADDR_FREQ_INT  = 8'h4F;
    localparam logic [7:0] ADDR_FREQ_FRAC = 8'h50;
    localparam logic [7:0] ADDR_SENSOR0   = 8'h51;

    // ------------------------------------------------------------
    // Field positions in rx_port_status_two
    // ------------------------------------------------------------
    localparam int BIT_UNSTEADY = 7;
    localparam int BIT_LEN_CHG  = 6;
    localparam int BIT_CODE     = 5;
    localparam int BIT_BUF      = 4;
    localparam int BIT_CAM      = 3;
    localparam int BIT_SETTLED  = 2;
    localparam int BIT_MISSING  = 1;
    localparam int BIT_CNT_CHG  = 0;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [1:0] RST_PORT_SEL   = 2'h0;
    localparam logic [7:0] CODE_LIMIT_MIN = 8'h01;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int REF_CLK_MHZ     = 100;
    // 256 us window: each counted edge is 1/256 MHz
    localparam int MEAS_WINDOW_US  = 256;
    localparam int MEAS_WINDOW_CYC = MEAS_WINDOW_US * REF_CLK_MHZ;

endpackage

// ===== rpsm_rate_meter.sv
// Purpose: Per-port link rate measurement
// Assumes: rate_clk_in is a divided link clock below 50 MHz
// Notes:   Result is integer MHz and 1/256 MHz fraction

`timescale 1ns/1ns

module rpsm_rate_meter
    import rpsm_pkg::*;
#(
    parameter int WINDOW_CYC = MEAS_WINDOW_CYC
)(
    // Clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       ce,
    // Rate sample and threshold
    input  wire logic       rate_clk_in,
    input  wire logic [7:0] rate_low_limit,
    // Results
    output logic      [7:0] rate_integer_mhz,
    output logic      [7:0] rate_fraction_mhz,
    output logic            rate_measure_settled,
    output logic            input_clock_missing
);

    localparam int WIN_W = $clog2(WINDOW_CYC + 1);
    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW_CYC - 1);

    typedef struct packed {
        logic [2:0]       sync;
        logic [WIN_W-1:0] win;
        logic [15:0]      edges;
        logic [15:0]      result;
        logic             have_one;
        logic             settled;
        logic             missing;
    } rpsm_meter_t;

    rpsm_meter_t st_reg;
    rpsm_meter_t st_next;
    logic        rise;
    logic        win_end;
    logic [15:0] edges_now;

    always_comb
    begin
        st_next   = st_reg;
        // sync[0] feeds only sync[1]; edges come from sync[1]/sync[2]
        st_next.sync = {st_reg.sync[1:0], rate_clk_in};
        rise      = st_reg.sync[1] & ~st_reg.sync[2];
        win_end   = (st_reg.win == WIN_LAST);
        edges_now = st_reg.edges;
        // Saturate rather than wrap on an out-of-range clock
        if (rise && (st_reg.edges != 16'hFFFF))
        begin
            edges_now = st_reg.edges + 16'h0001;
        end
        if (win_end)
        begin
            st_next.win      = '0;
            st_next.edges    = 16'h0000;
            st_next.result   = edges_now;
            st_next.have_one = 1'b1;
            st_next.settled  = st_reg.have_one &&
                (edges_now[15:8] == st_reg.result[15:8]); // see RULE10
            st_next.missing  = (edges_now[15:8] < rate_low_limit); // see RULE8
        end
        else
        begin
            st_next.win   = st_reg.win + 1'b1;
            st_next.edges = edges_now;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign rate_integer_mhz     = st_reg.result[15:8];
    assign rate_fraction_mhz    = st_reg.result[7:0];
    assign rate_measure_settled = st_reg.settled;
    assign input_clock_missing  = st_reg.missing;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_missing;
        @(posedge ref_clk) disable iff (srst)
        (ce && win_end) |=> (input_clock_missing ==
            ($past(edges_now[15:8]) < $past(rate_low_limit)));
    endproperty
    a_missing: assert property (p_missing) // see RULE8
        else $error("missing-clock flag disagrees with measurement");

    property p_fraction;
        @(posedge ref_clk) disable iff (srst)
        (ce && win_end) |=> (rate_fraction_mhz == $past(edges_now[7:0]))
            && (rate_integer_mhz == $past(edges_now[15:8]));
    endproperty
    a_fraction: assert property (p_fraction) // see RULE11
        else $error("rate bytes not loaded from window count");

    property p_settled;
        @(posedge ref_clk) disable iff (srst)
        (ce && win_end && !st_reg.have_one) |=> !rate_measure_settled;
    endproperty
    a_settled: assert property (p_settled) // see RULE10
        else $error("rate settled after a single window");

endmodule

// ===== rpsm_fwd_model.sv
// Purpose: Far-side model: link rate clocks and forward status bytes
// Assumes: One model serves all receive ports of the monitor
// Notes:   Bench sets half_ns per port; 0 parks that clock low

`timescale 1ns/1ns

module rpsm_fwd_model
    import rpsm_pkg::*;
#(
    parameter int NP = 4
)(
    // Clock
    input  wire logic          ref_clk,
    // Link side
    output logic [NP-1:0]      rate_clk_out,
    output logic [NP-1:0]      fwd_status_valid,
    output logic [NP-1:0][7:0] fwd_status_byte
);
    int half_ns [NP];

    initial
    begin
        rate_clk_out     = '0;
        fwd_status_valid = '0;
        fwd_status_byte  = {NP{8'hA5}};
        foreach (half_ns[i])
            half_ns[i] = 0;
    end

    // Odd idle step keeps clock phase unrelated to ref_clk
    for (genvar g = 0; g < NP; g++)
    begin : g_rate
        always
        begin
            if (half_ns[g] == 0)
            begin
                rate_clk_out[g] = 1'h0;
                #7;
            end
            else
            begin
                #(half_ns[g]);
                rate_clk_out[g] = ~rate_clk_out[g];
            end
        end
    end

    // Byte is inverted once valid drops so stale data never looks good
    task automatic send_status(input int p, input logic [7:0] b,
                               input int lag);
        repeat (lag) @(posedge ref_clk);
        fwd_status_byte[p]  <= b;
        fwd_status_valid[p] <= 1'h1;
        @(posedge ref_clk);
        fwd_status_valid[p] <= 1'h0;
        fwd_status_byte[p]  <= ~b;
    endtask
endmodule

// ===== rx_port_status_monitor_tb.sv
// Purpose: Self-checking bench of the receive-port status monitor
// Assumes: Short rate window of 2560 cycles, edge count tolerance 1
// Notes:   Bits 2:1 are masked, outside the reset and fault-count reads, until the rate scenario runs

`timescale 1ns/1ns

module rx_port_status_monitor_tb;
    import rpsm_pkg::*;

    localparam int NP = 4;
    localparam int EW = 5 * NP;
    localparam int WIN = 2560;

    logic                ref_clk = 1'h0;
    logic                srst = 1'h1;
    logic                ce = 1'h1;
    logic [7:0]          reg_addr = 8'h00;
    logic                reg_wr_en = 1'h0;
    logic                reg_rd_en = 1'h0;
    logic [7:0]          reg_wdata = 8'h00;
    logic [7:0]          reg_rdata;
    logic [4:0][NP-1:0]  ev = '0;
    logic [NP-1:0]       camera_rx_error = '0;
    logic                link_fault_count_en = 1'h0;
    logic [7:0]          link_fault_limit = 8'h00;
    logic [7:0]          rate_low_limit = 8'h00;
    logic [NP-1:0]       rate_clk;
    logic [NP-1:0]       fwd_valid;
    logic [NP-1:0][7:0]  fwd_byte;
    logic [4:0][NP-1:0]  e;
    logic [7:0]          d;
    logic [7:0]          fr;
    logic [15:0]         xc;
    int                  bad_count = 0;
    int                  samples_checked = 0;

    always #5 ref_clk = ~ref_clk;

    rpsm_port_status #(.NP(NP), .WINDOW_CYC(WIN)) rpsm_port_status_inst (
        .ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .row_width_unsteady_evt(ev[0]), .row_width_changed_evt(ev[1]),
        .row_count_changed_evt(ev[2]), .line_code_fault_evt(ev[3]),
        .packet_buf_overflow_evt(ev[4]), .camera_rx_error(camera_rx_error),
        .link_fault_count_en(link_fault_count_en),
        .link_fault_limit(link_fault_limit), .rate_low_limit(rate_low_limit),
        .rate_clk_in(rate_clk), .fwd_status_valid(fwd_valid),
        .fwd_status_byte(fwd_byte));

    rpsm_fwd_model #(.NP(NP)) rpsm_fwd_model_inst (
        .ref_clk(ref_clk), .rate_clk_out(rate_clk),
        .fwd_status_valid(fwd_valid), .fwd_status_byte(fwd_byte));

    task automatic final_report;
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr_en <= 1'h1;
        @(posedge ref_clk);
        reg_wr_en <= 1'h0;
    endtask

    // Read data stands until the next read, so sampling on the edge is safe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_rd_en <= 1'h1;
        @(posedge ref_clk);
        reg_rd_en <= 1'h0;
        @(posedge ref_clk);
        v = reg_rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
                       input logic [7:0] m);
        logic [7:0] v;
        rd(a, v);
        check(v & m, exp & m);
    endtask

    task automatic fire(input logic [4:0][NP-1:0] x);
        @(posedge ref_clk);
        ev <= x;
        @(posedge ref_clk);
        ev <= '0;
    endtask

    function automatic logic [7:0] flags(input logic [4:0][NP-1:0] x,
                                         input int p, input logic ok);
        return {x[0][p], x[1][p], x[3][p] & ok, x[4][p], 3'h0, x[2][p]};
    endfunction

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        bad_count++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'h6FCD6074));
        repeat (6) @(posedge ref_clk);
        srst <= 1'h0;
        for (int a = 32'h4C; a <= 32'h51; a++)
            rdc(a[7:0], 8'h00, 8'hFF);
        rdc(8'h40, 8'h00, 8'hFF);
        link_fault_count_en <= 1'h1;
        link_fault_limit    <= 8'h02;
        for (int n = 0; n < 4; n++)
        begin
            e = (n == 0) ? '1 : EW'($urandom);
            fire(e);
            for (int p = 0; p < NP; p++)
            begin
                wr(ADDR_PORT_SEL, p[7:0]);
                rdc(ADDR_PORT_SEL, p[7:0], 8'hFF);
                rdc(ADDR_STS_TWO, flags(e, p, 1'h1), 8'hF9);
                rdc(ADDR_STS_TWO, 8'h00, 8'hF9);
            end
        end
        for (int c = 0; c < 4; c++)
        begin
            link_fault_count_en <= c[0];
            link_fault_limit    <= c[1] ? 8'h02 : 8'h01;
            fire({NP'(0), {NP{1'b1}}, NP'(0), NP'(0), NP'(0)});
            rdc(ADDR_STS_TWO, {2'h0, c == 3, 5'h0}, 8'hFF);
        end
        camera_rx_error <= 4'h8;
        rdc(ADDR_STS_TWO, 8'h08, 8'h08);
        rdc(ADDR_STS_TWO, 8'h08, 8'h08);
        camera_rx_error <= 4'h0;
        rdc(ADDR_STS_TWO, 8'h00, 8'h08);
        @(posedge ref_clk);
        reg_addr  <= ADDR_STS_TWO;
        reg_rd_en <= 1'h1;
        ev[2]     <= 4'h8;
        @(posedge ref_clk);
        reg_rd_en <= 1'h0;
        ev        <= '0;
        @(posedge ref_clk);
        check(reg_rdata & 8'hF9, 8'h00);
        rdc(ADDR_STS_TWO, 8'h01, 8'hF9);
        rdc(ADDR_STS_TWO, 8'h00, 8'hF9);
        wr(ADDR_STS_TWO, 8'hFF);
        rdc(ADDR_STS_TWO, 8'h00, 8'hF9);
        wr(ADDR_PORT_SEL, 8'h06);
        ce <= 1'h0;
        wr(ADDR_PORT_SEL, 8'h01);
        ce <= 1'h1;
        rdc(ADDR_PORT_SEL, 8'h03, 8'hFF);
        for (int p = 0; p < NP; p++)
        begin
            wr(ADDR_PORT_SEL, p[7:0]);
            d = 8'($urandom);
            rpsm_fwd_model_inst.send_status(p, d, 1 + p);
            repeat (2) @(posedge ref_clk);
            rdc(ADDR_SENSOR0, d, 8'hFF);
            wr(ADDR_SENSOR0, ~d);
            rdc(ADDR_SENSOR0, d, 8'hFF);
        end
        rate_low_limit <= 8'h02;
        rpsm_fwd_model_inst.half_ns = '{40, 20, 0, 32};
        repeat (4 * WIN + 20) @(posedge ref_clk);
        for (int p = 0; p < NP; p++)
        begin
            xc = (rpsm_fwd_model_inst.half_ns[p] == 0) ? 16'h0000 :
                 16'(WIN * 5 / rpsm_fwd_model_inst.half_ns[p]);
            wr(ADDR_PORT_SEL, p[7:0]);
            rdc(ADDR_FREQ_INT, xc[15:8], 8'hFF);
            rd(ADDR_FREQ_FRAC, fr);
            if (fr + 8'h01 == xc[7:0] || fr == xc[7:0] + 8'h01)
                fr = xc[7:0];
            check(fr, xc[7:0]);
            rdc(ADDR_STS_TWO, {5'h0, 1'h1, xc[15:8] < 8'h02, 1'h0},
                8'h06);
        end
        final_report();
    end
endmodule
